// file: hw/uef_defs.svh
// Register offsets, field positions, reset values and sizes of the endpoint control block
`ifndef UEF_DEFS_SVH
`define UEF_DEFS_SVH

`define UEF_OFF_CLEAR 8'h00
`define UEF_OFF_STALL 8'h04
`define UEF_OFF_SCM 8'h08
`define UEF_OFF_SIZE 8'h0C
`define UEF_OFF_SETUP 8'h10
`define UEF_OFF_CIN 8'h14
`define UEF_OFF_COUT 8'h18

`define UEF_CLR_EP2 5
`define UEF_CLR_EP1 4
`define UEF_CLR_EP3 3
`define UEF_CLR_EP0O 2
`define UEF_CLR_EP0I 1

`define UEF_STL_EP2 5
`define UEF_STL_EP1 4
`define UEF_STL_EP3 3
`define UEF_STL_EP0 0

`define UEF_SCM_BIT 7

`define UEF_RST_BYTE 8'h00
`define UEF_RST_WORD 32'h0000_0000

`define UEF_FIFO_DEPTH 8
`define UEF_SETUP_LEN 8

`endif

// file: hw/uef_pkg.sv
// Types shared by the endpoint control block
package uef_pkg;

    typedef enum logic {ST_IDLE, ST_MOVE} uef_state_e;

    typedef enum logic [1:0] {PORT_NONE, PORT_SETUP, PORT_CIN, PORT_COUT} uef_port_e;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic [2:0] size;
    } uef_ap_s;

    typedef struct packed {
        logic [1:0] ep2;
        logic [1:0] ep1;
        logic ep3;
        logic ep0o;
        logic ep0i;
    } uef_clear_s;

    typedef struct packed {
        logic ep3;
        logic ep2;
        logic ep1;
        logic ep0;
    } uef_stall_s;

    typedef struct packed {
        logic start;
        logic valid;
        logic [7:0] data;
        logic done;
    } uef_setup_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic done;
    } uef_rx_s;

endpackage : uef_pkg

// file: hw/uef_byte_fifo.sv
// Byte FIFO with a commit point; bytes past the commit point are not yet visible to the reader
`timescale 1ns/1ns
`include "uef_defs.svh"
module uef_byte_fifo (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hce,
    input wire logic flush,
    input wire logic push,
    input wire logic [7:0] wdata,
    input wire logic commit,
    input wire logic pop,
    output logic [7:0] rdata,
    output logic [3:0] avail
);
    import uef_pkg::*;

    logic [7:0] mem [`UEF_FIFO_DEPTH];
    logic [3:0] wr_ptr_r;
    logic [3:0] cm_ptr_r;
    logic [3:0] rd_ptr_r;
    logic [3:0] fill;
    logic do_push;
    logic do_pop;

    assign fill = 4'(wr_ptr_r - rd_ptr_r);
    assign avail = 4'(cm_ptr_r - rd_ptr_r);
    // Pushes into a full FIFO are dropped so committed data is never overwritten
    assign do_push = push && (fill != 4'(`UEF_FIFO_DEPTH));
    assign do_pop = pop && (avail != 4'h0);
    assign rdata = mem[rd_ptr_r[2:0]];

    always_ff @(posedge hclk) begin
        if (hce && do_push && !flush) begin
            mem[wr_ptr_r[2:0]] <= wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_r <= 4'h0;
            cm_ptr_r <= 4'h0;
            rd_ptr_r <= 4'h0;
        end else if (hce) begin
            if (flush) begin
                // Drops committed and uncommitted bytes alike
                wr_ptr_r <= 4'h0; // [R3] [R4]
                cm_ptr_r <= 4'h0;
                rd_ptr_r <= 4'h0;
            end else begin
                if (do_push) begin
                    wr_ptr_r <= 4'(wr_ptr_r + 4'h1);
                end
                if (commit) begin
                    cm_ptr_r <= do_push ? 4'(wr_ptr_r + 4'h1) : wr_ptr_r;
                end
                if (do_pop) begin
                    rd_ptr_r <= 4'(rd_ptr_r + 4'h1);
                end
            end
        end
    end

endmodule : uef_byte_fifo

// file: hw/uef_ep_ctrl.sv
// Endpoint FIFO clear, stall control and endpoint 0 data ports behind an AHB-Lite slave
//
// Behaviour
// R1: Writing 1 to a clear bit flushes that FIFO once; writing 0 does nothing.
// R2: Clear bits: 5 EP2 OUT, 4 EP1 IN, 3 EP3 IN, 2 EP0 OUT, 1 EP0 IN.
// R3: Clearing an IN FIFO drops both unvalidated and validated bytes.
// R4: Clearing an OUT FIFO drops incomplete and unread received bytes.
// R5: For dual-bank endpoints 1 and 2, a clear empties both banks.
// R6: A clear leaves the endpoint interrupt flag untouched.
// R7: Software avoids clearing a FIFO in the middle of a packet.
// R8: Reserved clear bits 7,6,0 and stall bits 7,6,2,1 read 0, ignore writes.
// R9: A set stall bit makes the endpoint answer STALL from the next transfer.
// R10: Stall bits 5 EP2, 4 EP1, 3 EP3, 0 EP0 are read/write, reset 0.
// R11: EP0 stall clears itself when a decoded 8-byte setup command arrives.
// R12: While the setup-received flag is set, writing 1 to EP0 stall is ignored.
// R13: Software writes 0 to stall-cancel mode bit 7; bits 6 to 0 read 0.
// R14: The setup port is read-only and holds the 8-byte setup command.
// R15: Each byte port spans 4 addresses; wider accesses move 2 or 4 bytes.
// R16: Software writes control-in data, never more than max packet size.
// R17: Software reads exactly the reported control-out size in bytes.
// R18: Each control-out byte read lowers the control-out size by one.
// R19: Packet-enable validates written IN bytes for transmission.
// R20: Software issues read-complete after reading so the next packet fits.
// R21: Clear bits read back 0 and pulse for one cycle per write.
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`include "uef_defs.svh"
module uef_ep_ctrl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic setup_received_flag,
    input wire uef_pkg::uef_setup_s setup_in,
    input wire logic packet_enable_trigger,
    input wire logic read_complete_trigger,
    input wire uef_pkg::uef_rx_s rx_in,
    input wire logic tx_req,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output uef_pkg::uef_stall_s ep_stall,
    output uef_pkg::uef_clear_s fifo_clear
);
    import uef_pkg::*;

    uef_state_e state_r;
    uef_ap_s ap_r;
    logic [1:0] cnt_r;
    logic wpend_r;
    logic hreadyout_r;
    logic hresp_r;
    logic [31:0] hrdata_r;
    uef_stall_s stall_r;
    uef_clear_s clr_r;
    logic scm_r;
    logic tx_valid_r;
    logic [7:0] tx_data_r;

    logic [7:0] setup_mem [`UEF_SETUP_LEN];
    logic [2:0] swr_idx_r;
    logic [2:0] srd_idx_r;

    logic acc;
    logic in_move;
    logic last;
    logic [1:0] lane;
    uef_port_e mv_port;
    logic [7:0] rd_byte;
    logic cin_push;
    logic [7:0] cin_wdata;
    logic cin_pop;
    logic [7:0] cin_rdata;
    logic [3:0] cin_avail;
    logic cout_pop;
    logic [7:0] cout_rdata;
    logic [3:0] cout_avail;
    logic setup_rd;

    // Data ports are decoded over a whole word window; wrong direction counts as a plain register
    function automatic uef_port_e port_of(input logic [7:0] a, input logic wr);
        uef_port_e p;
        p = PORT_NONE;
        if ({a[7:2], 2'b00} == `UEF_OFF_SETUP && !wr) begin
            p = PORT_SETUP; // [R14] [R15]
        end else if ({a[7:2], 2'b00} == `UEF_OFF_CIN && wr) begin
            p = PORT_CIN;
        end else if ({a[7:2], 2'b00} == `UEF_OFF_COUT && !wr) begin
            p = PORT_COUT;
        end
        return p;
    endfunction : port_of

    function automatic logic [1:0] last_idx(input logic [2:0] sz);
        logic [1:0] n;
        if (sz == 3'h0) begin
            n = 2'h0;
        end else if (sz == 3'h1) begin
            n = 2'h1;
        end else begin
            n = 2'h3;
        end
        return n;
    endfunction : last_idx

    function automatic logic [31:0] reg_read(input logic [7:0] a);
        logic [7:0] b;
        b = `UEF_RST_BYTE;
        if (a == `UEF_OFF_CLEAR) begin
            b = `UEF_RST_BYTE; // [R21] [R8]
        end else if (a == `UEF_OFF_STALL) begin
            b[`UEF_STL_EP2] = stall_r.ep2; // [R10] [R8]
            b[`UEF_STL_EP1] = stall_r.ep1;
            b[`UEF_STL_EP3] = stall_r.ep3;
            b[`UEF_STL_EP0] = stall_r.ep0;
        end else if (a == `UEF_OFF_SCM) begin
            b[`UEF_SCM_BIT] = scm_r;
        end else if (a == `UEF_OFF_SIZE) begin
            b = {4'h0, cout_avail};
        end
        return {24'h000000, b};
    endfunction : reg_read

    assign acc = hready && hsel && htrans[1] && (state_r == ST_IDLE);
    assign in_move = (state_r == ST_MOVE);
    assign mv_port = port_of(ap_r.addr, ap_r.write);
    assign lane = 2'(ap_r.addr[1:0] + cnt_r);
    assign last = (cnt_r == last_idx(ap_r.size));
    assign cin_push = in_move && (mv_port == PORT_CIN);
    assign cin_wdata = hwdata[{lane, 3'b000} +: 8];
    assign cout_pop = in_move && (mv_port == PORT_COUT);
    assign setup_rd = in_move && (mv_port == PORT_SETUP);
    assign cin_pop = tx_req;

    always_comb begin
        rd_byte = `UEF_RST_BYTE;
        case (mv_port)
            PORT_SETUP: rd_byte = setup_mem[srd_idx_r];
            PORT_COUT: rd_byte = (cout_avail != 4'h0) ? cout_rdata : `UEF_RST_BYTE;
            default: rd_byte = `UEF_RST_BYTE;
        endcase
    end

    // Port accesses take one wait cycle per byte so the FIFOs move one byte at a time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
            ap_r <= '0;
            cnt_r <= 2'h0;
            wpend_r <= 1'b0;
            hreadyout_r <= 1'b1;
            hrdata_r <= `UEF_RST_WORD;
        end else if (hce) begin
            wpend_r <= acc && hwrite && (port_of(haddr[7:0], hwrite) == PORT_NONE);
            if (acc) begin
                ap_r <= '{addr: haddr[7:0], write: hwrite, size: hsize};
                cnt_r <= 2'h0;
                if (port_of(haddr[7:0], hwrite) != PORT_NONE) begin
                    state_r <= ST_MOVE;
                    hreadyout_r <= 1'b0;
                    hrdata_r <= `UEF_RST_WORD;
                end else if (!hwrite) begin
                    hrdata_r <= reg_read(haddr[7:0]);
                end
            end else if (in_move) begin
                if (!ap_r.write) begin
                    hrdata_r[{lane, 3'b000} +: 8] <= rd_byte; // [R15]
                end
                cnt_r <= 2'(cnt_r + 2'h1);
                if (last) begin
                    state_r <= ST_IDLE;
                    hreadyout_r <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_r <= 1'b0;
        end else begin
            hresp_r <= 1'b0;
        end
    end

    // The interrupt flags outside are left alone; nothing here touches them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clr_r <= '0;
        end else if (hce) begin
            clr_r <= '0; // [R21]
            if (wpend_r && ap_r.addr == `UEF_OFF_CLEAR) begin
                clr_r.ep2 <= {2{hwdata[`UEF_CLR_EP2]}}; // [R1] [R2] [R5] [R6]
                clr_r.ep1 <= {2{hwdata[`UEF_CLR_EP1]}}; // [R5]
                clr_r.ep3 <= hwdata[`UEF_CLR_EP3];
                clr_r.ep0o <= hwdata[`UEF_CLR_EP0O];
                clr_r.ep0i <= hwdata[`UEF_CLR_EP0I];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stall_r <= '0; // [R10]
        end else if (hce) begin
            if (wpend_r && ap_r.addr == `UEF_OFF_STALL) begin
                stall_r.ep2 <= hwdata[`UEF_STL_EP2]; // [R10] [R9]
                stall_r.ep1 <= hwdata[`UEF_STL_EP1];
                stall_r.ep3 <= hwdata[`UEF_STL_EP3];
                if (!(setup_received_flag && hwdata[`UEF_STL_EP0])) begin
                    stall_r.ep0 <= hwdata[`UEF_STL_EP0]; // [R12]
                end
            end
            // A decoded setup command releases the control stall, overriding a same-cycle write
            if (setup_in.done) begin
                stall_r.ep0 <= 1'b0; // [R11]
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scm_r <= 1'b0;
        end else if (hce && wpend_r && ap_r.addr == `UEF_OFF_SCM) begin
            scm_r <= hwdata[`UEF_SCM_BIT];
        end
    end

    always_ff @(posedge hclk) begin
        if (hce && setup_in.valid) begin
            setup_mem[swr_idx_r] <= setup_in.data; // [R14]
        end
    end

    // The setup store is always overwritable; reading restarts at byte 0 once a command lands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            swr_idx_r <= 3'h0;
            srd_idx_r <= 3'h0;
        end else if (hce) begin
            if (setup_in.start) begin
                swr_idx_r <= 3'h0;
            end else if (setup_in.valid) begin
                swr_idx_r <= 3'(swr_idx_r + 3'h1);
            end
            if (setup_in.done) begin
                srd_idx_r <= 3'h0;
            end else if (setup_rd) begin
                srd_idx_r <= 3'(srd_idx_r + 3'h1);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_valid_r <= 1'b0;
            tx_data_r <= `UEF_RST_BYTE;
        end else if (hce) begin
            tx_valid_r <= tx_req && (cin_avail != 4'h0);
            if (tx_req && (cin_avail != 4'h0)) begin
                tx_data_r <= cin_rdata;
            end
        end
    end

    uef_byte_fifo u_cin (
        .hclk(hclk),
        .hresetn(hresetn),
        .hce(hce),
        .flush(clr_r.ep0i), // [R1] [R3]
        .push(cin_push),
        .wdata(cin_wdata),
        .commit(packet_enable_trigger), // [R19]
        .pop(cin_pop),
        .rdata(cin_rdata),
        .avail(cin_avail)
    );

    // Read-complete drops any unread remainder so the next packet starts empty
    uef_byte_fifo u_cout (
        .hclk(hclk),
        .hresetn(hresetn),
        .hce(hce),
        .flush(clr_r.ep0o || read_complete_trigger), // [R4] [R20]
        .push(rx_in.valid),
        .wdata(rx_in.data),
        .commit(rx_in.done),
        .pop(cout_pop), // [R18]
        .rdata(cout_rdata),
        .avail(cout_avail)
    );

    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign hrdata = hrdata_r;
    assign tx_valid = tx_valid_r;
    assign tx_data = tx_data_r;
    assign ep_stall = stall_r; // [R9]
    assign fifo_clear = clr_r;

endmodule : uef_ep_ctrl

// file: verif/uef_ep_ctrl_asserts.sv
// Port-level checks for the endpoint control block
`timescale 1ns/1ns
module uef_ep_ctrl_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic setup_received_flag,
    input wire uef_pkg::uef_setup_s setup_in,
    input wire logic tx_req,
    input wire logic tx_valid,
    input wire uef_pkg::uef_stall_s ep_stall,
    input wire uef_pkg::uef_clear_s fifo_clear
);
    import uef_pkg::*;
    logic wr_take;
    assign wr_take = hsel && htrans[1] && hwrite && hreadyout;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    property p_clr_once; |fifo_clear |=> fifo_clear == '0; endproperty
    property p_clr_bank; fifo_clear.ep2 != 2'h1 && fifo_clear.ep1 != 2'h1; endproperty
    property p_clr_cause; |fifo_clear |-> $past(wr_take, 2); endproperty
    property p_auto; setup_in.done |=> !ep_stall.ep0; endproperty
    property p_flag; setup_received_flag && !ep_stall.ep0 |=> !ep_stall.ep0; endproperty
    property p_chg; $changed(ep_stall) |-> $past(setup_in.done) || $past(wr_take, 2); endproperty
    property p_tx; tx_valid |-> $past(tx_req); endproperty
    // A word port access holds the bus for four cycles at most
    property p_wait; $fell(hreadyout) |-> ##[1:4] hreadyout; endproperty
    a_clr_once: assert property (p_clr_once) else $error("clear pulse too long");
    a_clr_bank: assert property (p_clr_bank) else $error("one bank cleared");
    a_clr_cause: assert property (p_clr_cause) else $error("clear without write");
    a_auto: assert property (p_auto) else $error("stall kept after setup");
    a_flag: assert property (p_flag) else $error("stall set under flag");
    a_chg: assert property (p_chg) else $error("stall changed alone");
    a_tx: assert property (p_tx) else $error("byte without request");
    a_wait: assert property (p_wait) else $error("port wait too long");
    c_auto: cover property (setup_in.done && ep_stall.ep0);
    c_long: cover property ($fell(hreadyout) ##4 hreadyout);
    c_bank: cover property (fifo_clear.ep1 == 2'h3);
endmodule : uef_ep_ctrl_asserts

bind uef_ep_ctrl uef_ep_ctrl_asserts i_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
    .hreadyout, .setup_received_flag, .setup_in, .tx_req, .tx_valid, .ep_stall, .fifo_clear);

// file: verif/uef_host_model.sv
// Link-side model: setup and OUT packets in, IN bytes pulled out
`timescale 1ns/1ns
module uef_host_model (
    input wire logic hclk,
    output uef_pkg::uef_setup_s setup_in,
    output uef_pkg::uef_rx_s rx_in,
    output logic tx_req
);
    import uef_pkg::*;
    initial begin
        setup_in = '0;
        rx_in = '0;
        tx_req = 1'h0;
    end
    // Data shows the inverse of the previous cycle's data when idle, so it always differs from the byte on the cycle before
    task automatic frame(input logic su, input logic [63:0] b, input int n, input logic fin);
        logic [7:0] d = 8'h00;
        logic v;
        for (int i = 0; i <= n + 2; i++) begin
            @(posedge hclk);
            v = i > 0 && i <= n;
            d = v ? b[8*(i-1)+:8] : ~d;
            setup_in <= {su && i == 0, su && v, d, su && i == n + 1};
            rx_in <= {!su && v, d, !su && fin && i == n + 1};
        end
    endtask : frame
    task automatic pull(input int n);
        repeat (n) begin
            @(posedge hclk);
            tx_req <= 1'h1;
            @(posedge hclk);
            tx_req <= 1'h0;
        end
    endtask : pull
endmodule : uef_host_model

// file: verif/test_uef_ep_ctrl.sv
// Self-checking bench for the endpoint control block
`timescale 1ns/1ns
`include "uef_defs.svh"
module test_uef_ep_ctrl;
    import uef_pkg::*;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hce = 1'h1;
    logic hsel = 1'h1;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = '0;
    logic [31:0] hwdata = '0;
    logic flag = 1'h0;
    logic pke = 1'h0;
    logic rdc = 1'h0;
    logic hreadyout, hresp, tx_valid, tx_req, dp_rd;
    logic [31:0] hrdata, d;
    logic [31:0] lfsr = 32'hD868;
    logic [7:0] tx_data;
    logic [63:0] su;
    uef_setup_s setup_in;
    uef_rx_s rx_in;
    uef_stall_s ep_stall;
    uef_clear_s fifo_clear;
    logic [31:0] exp_q[$], msk_q[$], tx_q[$], clr_q[$];
    int n_fail = 0;
    int n_checks = 0;
    always #25 hclk = ~hclk;
    uef_ep_ctrl i_dut (.hclk, .hresetn, .hce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .setup_received_flag(flag), .setup_in,
        .packet_enable_trigger(pke), .read_complete_trigger(rdc), .rx_in, .tx_req, .tx_valid,
        .tx_data, .ep_stall, .fifo_clear);
    uef_host_model i_host (.hclk, .setup_in, .rx_in, .tx_req);
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    function automatic logic [31:0] pop(ref logic [31:0] q[$]);
        return q.size() ? q.pop_front() : 32'hDEAD_BEEF;
    endfunction : pop
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_rdy();
        int k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'h1) begin
            k++;
            if (k > 40) begin
                n_fail++;
                wrap_up();
            end
            @(posedge hclk);
        end
    endtask : wait_rdy
    // Called just after a rising edge; a read notes its expectation for the monitor
    task automatic xfer(input logic w, input logic [7:0] a, input logic [2:0] s,
                        input logic [31:0] dv, input logic [31:0] m);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= s;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= dv;
        if (!w) begin
            exp_q.push_back(dv);
            msk_q.push_back(m);
        end
        wait_rdy();
        chk({31'h0, hresp}, 32'h0);
    endtask : xfer
    task automatic pulse_pke();
        pke <= 1'h1;
        @(posedge hclk);
        pke <= 1'h0;
    endtask : pulse_pke
    always @(posedge hclk) begin
        if (dp_rd === 1'h1 && hreadyout === 1'h1) begin
            chk(hrdata & pop(msk_q), pop(exp_q));
            dp_rd = 1'h0;
        end
        if (htrans[1] && !hwrite && hreadyout === 1'h1)
            dp_rd = 1'h1;
        if (tx_valid === 1'h1)
            chk({24'h0, tx_data}, pop(tx_q));
        if (|fifo_clear === 1'h1)
            chk({25'h0, fifo_clear}, pop(clr_q));
    end
    initial begin
        dp_rd = 1'h0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        xfer(0, `UEF_OFF_STALL, 3'h2, 32'h0, 32'hFFFF_FFFF);
        xfer(0, `UEF_OFF_CLEAR, 3'h2, 32'h0, 32'hFFFF_FFFF);
        xfer(0, `UEF_OFF_SCM, 3'h2, 32'h0, 32'hFFFF_FFFF);
        xfer(0, 8'h40, 3'h2, 32'h0, 32'hFFFF_FFFF);
        xfer(1, `UEF_OFF_SCM, 3'h2, 32'h7F, 32'h0);
        xfer(0, `UEF_OFF_SCM, 3'h2, 32'h0, 32'hFFFF_FFFF);
        $display("done: reset values");
        xfer(1, `UEF_OFF_STALL, 3'h2, 32'hFFFF_FFFF, 32'h0);
        xfer(0, `UEF_OFF_STALL, 3'h2, 32'h39, 32'hFFFF_FFFF);
        chk({28'h0, ep_stall}, 32'hF);
        xfer(1, `UEF_OFF_STALL, 3'h2, 32'h0, 32'h0);
        xfer(0, `UEF_OFF_STALL, 3'h2, 32'h0, 32'hFF);
        $display("done: stall bits");
        flag <= 1'h1;
        xfer(1, `UEF_OFF_STALL, 3'h2, 32'h1, 32'h0);
        xfer(0, `UEF_OFF_STALL, 3'h2, 32'h0, 32'hFF);
        flag <= 1'h0;
        xfer(1, `UEF_OFF_STALL, 3'h2, 32'h31, 32'h0);
        su = {rnd(), rnd()};
        i_host.frame(1'h1, su, 8, 1'h1);
        @(posedge hclk);
        xfer(0, `UEF_OFF_STALL, 3'h2, 32'h30, 32'hFF);
        xfer(0, `UEF_OFF_SETUP, 3'h2, su[31:0], 32'hFFFF_FFFF);
        xfer(0, `UEF_OFF_SETUP + 8'h2, 3'h1, {su[47:32], 16'h0}, 32'hFFFF_0000);
        xfer(0, `UEF_OFF_SETUP, 3'h0, {24'h0, su[55:48]}, 32'hFF);
        $display("done: setup and stall release");
        xfer(1, `UEF_OFF_CLEAR, 3'h2, 32'h0, 32'h0);
        for (int i = 0; i < 8; i++) begin
            if (i inside {[1:5]})
                clr_q.push_back(i == 5 ? 32'h60 : i == 4 ? 32'h18 : 32'h1 << (i - 1));
            xfer(1, `UEF_OFF_CLEAR, 3'h2, 32'h1 << i, 32'h0);
            xfer(0, `UEF_OFF_CLEAR, 3'h2, 32'h0, 32'hFFFF_FFFF);
        end
        $display("done: clear triggers");
        su = {rnd(), rnd()};
        i_host.frame(1'h0, su, 4, 1'h0);
        @(posedge hclk);
        clr_q.push_back(32'h2);
        // The cut frame has ended on the link before the clear is issued
        xfer(1, `UEF_OFF_CLEAR, 3'h2, 32'h4, 32'h0);
        i_host.frame(1'h0, su, 4, 1'h1);
        @(posedge hclk);
        xfer(0, `UEF_OFF_SIZE, 3'h2, 32'h4, 32'hFF);
        xfer(0, `UEF_OFF_COUT, 3'h1, {16'h0, su[15:0]}, 32'hFFFF);
        xfer(0, `UEF_OFF_SIZE, 3'h2, 32'h2, 32'hFF);
        xfer(0, `UEF_OFF_COUT + 8'h2, 3'h1, {su[31:16], 16'h0}, 32'hFFFF_0000);
        xfer(0, `UEF_OFF_SIZE, 3'h2, 32'h0, 32'hFF);
        rdc <= 1'h1;
        @(posedge hclk);
        rdc <= 1'h0;
        xfer(0, `UEF_OFF_SIZE, 3'h2, 32'h0, 32'hFF);
        // A packet arriving while the enable is low must leave no trace
        hce <= 1'h0;
        i_host.frame(1'h0, su, 4, 1'h1);
        hce <= 1'h1;
        xfer(0, `UEF_OFF_SIZE, 3'h2, 32'h0, 32'hFF);
        $display("done: control out");
        d = rnd();
        xfer(1, `UEF_OFF_CIN, 3'h2, d, 32'h0);
        pulse_pke();
        tx_q.push_back({24'h0, d[7:0]});
        tx_q.push_back({24'h0, d[15:8]});
        i_host.pull(2);
        @(posedge hclk);
        xfer(1, `UEF_OFF_CIN, 3'h1, rnd(), 32'h0);
        clr_q.push_back(32'h1);
        xfer(1, `UEF_OFF_CLEAR, 3'h2, 32'h2, 32'h0);
        pulse_pke();
        i_host.pull(4);
        repeat (4) @(posedge hclk);
        $display("done: control in");
        chk(exp_q.size() + tx_q.size() + clr_q.size(), 32'h0);
        wrap_up();
    end
endmodule : test_uef_ep_ctrl
